//--- logic/cbd_branch_decode.sv
// Compare and decrement branch executor with status word and register slave.
`timescale 1ns/1ns
`default_nettype none

module cbd_branch_decode #(
	parameter int RAM_AW = 8
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [cbd_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [cbd_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic                           exec_busy
);

	// ------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------
	logic [7:0]          aw_addr_reg;
	logic                aw_hold_reg;
	logic [31:0]         w_data_reg;
	logic [3:0]          w_strb_reg;
	logic                w_hold_reg;
	logic [23:0]         instr_reg;
	logic [15:0]         pc_reg;
	logic [7:0]          acc_reg;
	logic [7:0]          psw_reg;
	logic [7:0]          dbg_addr_reg;
	logic [2:0]          cyc_reg;
	logic [2:0]          last_cyc_reg;
	logic                taken_reg;
	logic                call_reg;
	logic                unsup_reg;
	cbd_pkg::cbd_state_t state_reg;
	cbd_pkg::cbd_state_t state_next;
	logic [7:0]          ram_rdata;

	// ------------------------------------------------------------------
	// Register bus write channel.
	// ------------------------------------------------------------------
	wire aw_take  = s_axi_awvalid & s_axi_awready;
	wire w_take   = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	wire aw_hold_next = do_write ? 1'b0 : (aw_hold_reg | aw_take);
	wire w_hold_next  = do_write ? 1'b0 : (w_hold_reg | w_take);
	wire idle     = (state_reg == cbd_pkg::ST_IDLE);

	// Write decode; everything but the control word is frozen while busy.
	wire wr_ctrl  = do_write & (aw_addr_reg == cbd_pkg::OFF_CTRL);
	wire wr_instr = do_write & idle & (aw_addr_reg == cbd_pkg::OFF_INSTR);
	wire wr_pc    = do_write & idle & (aw_addr_reg == cbd_pkg::OFF_PC);
	wire wr_acc   = do_write & idle & (aw_addr_reg == cbd_pkg::OFF_ACC) & w_strb_reg[0];
	wire wr_daddr = do_write & idle & (aw_addr_reg == cbd_pkg::OFF_DADDR) & w_strb_reg[0];
	wire wr_data  = do_write & idle & (aw_addr_reg == cbd_pkg::OFF_DATA) & w_strb_reg[0];
	wire wr_psw   = do_write & idle & (aw_addr_reg == cbd_pkg::OFF_PSW) & w_strb_reg[0];
	wire wr_hit   = (aw_addr_reg == cbd_pkg::OFF_CTRL) | (aw_addr_reg == cbd_pkg::OFF_INSTR)
		| (aw_addr_reg == cbd_pkg::OFF_PC) | (aw_addr_reg == cbd_pkg::OFF_ACC)
		| (aw_addr_reg == cbd_pkg::OFF_STATUS) | (aw_addr_reg == cbd_pkg::OFF_DADDR)
		| (aw_addr_reg == cbd_pkg::OFF_DATA) | (aw_addr_reg == cbd_pkg::OFF_PSW);
	wire start_now = wr_ctrl & idle & w_strb_reg[0] & w_data_reg[cbd_pkg::CTRL_START];

	// Address and data are held separately so either may arrive first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= cbd_pkg::RESP_OKAY;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
		end else begin
			aw_hold_reg   <= aw_hold_next;
			w_hold_reg    <= w_hold_next;
			s_axi_awready <= ~aw_hold_next;
			s_axi_wready  <= ~w_hold_next;
			if (aw_take) aw_addr_reg <= s_axi_awaddr;
			if (w_take) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? cbd_pkg::RESP_OKAY : cbd_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Instruction decode and operand addressing.
	// ------------------------------------------------------------------
	wire [7:0] op_byte  = instr_reg[7:0];
	wire [7:0] byte1    = instr_reg[15:8];
	wire [7:0] byte2    = instr_reg[23:16];
	wire cbd_pkg::cbd_class_t cls = cbd_pkg::cbd_classify(op_byte);
	wire [1:0] ins_len  = cbd_pkg::cbd_length(cls);
	wire [2:0] base_cyc = cbd_pkg::cbd_base_cycles(cls);
	wire [1:0] bank     = psw_reg[cbd_pkg::PSW_BANK_LSB +: 2];
	wire is_cj   = (cls == cbd_pkg::CL_CJ_DIR) | (cls == cbd_pkg::CL_CJ_IMM)
		| (cls == cbd_pkg::CL_CJ_REG) | (cls == cbd_pkg::CL_CJ_IND);
	wire is_dj   = (cls == cbd_pkg::CL_DJ_REG) | (cls == cbd_pkg::CL_DJ_DIR);
	wire is_dir  = (cls == cbd_pkg::CL_CJ_DIR) | (cls == cbd_pkg::CL_DJ_DIR);
	wire is_reg  = (cls == cbd_pkg::CL_CJ_REG) | (cls == cbd_pkg::CL_DJ_REG);
	wire is_page = (cls == cbd_pkg::CL_PG_JUMP) | (cls == cbd_pkg::CL_PG_CALL);
	wire is_long = (cls == cbd_pkg::CL_LG_JUMP) | (cls == cbd_pkg::CL_LG_CALL);
	wire dir_sfr = byte1[cbd_pkg::SFR_SEL_BIT];

	// First operand address: bank register, pointer register or direct byte.
	wire [7:0] reg_addr = cbd_pkg::cbd_bank_addr(bank, op_byte[2:0]);
	wire [7:0] ptr_addr = cbd_pkg::cbd_bank_addr(bank, {2'h0, op_byte[0]});
	wire [7:0] first_addr = is_dir ? byte1 : is_reg ? reg_addr
		: (cls == cbd_pkg::CL_CJ_IND) ? ptr_addr : 8'h00;

	// The second read of an indirect compare uses the pointer just fetched.
	wire indir_step = (state_reg == cbd_pkg::ST_OPND) & (cls == cbd_pkg::CL_CJ_IND);
	wire [7:0] core_rd_addr = indir_step ? ram_rdata : first_addr;
	wire [7:0] ram_raddr = (idle & ~start_now) ? dbg_addr_reg : core_rd_addr;

	// ------------------------------------------------------------------
	// Evaluation of compare, decrement and branch targets.
	// ------------------------------------------------------------------
	wire eval = ((state_reg == cbd_pkg::ST_OPND) & (cls != cbd_pkg::CL_CJ_IND))
		| (state_reg == cbd_pkg::ST_INDIR);
	wire [7:0] sfr_rd = (byte1 == cbd_pkg::SFR_PSW) ? psw_reg
		: (byte1 == cbd_pkg::SFR_ACC) ? acc_reg : 8'h00;
	wire [7:0] opnd  = (is_dir & dir_sfr) ? sfr_rd : ram_rdata;
	wire [7:0] cmp_a = ((cls == cbd_pkg::CL_CJ_DIR) | (cls == cbd_pkg::CL_CJ_IMM)) ? acc_reg : opnd;
	wire [7:0] cmp_b = (cls == cbd_pkg::CL_CJ_DIR) ? opnd : byte1;
	wire cmp_ne  = (cmp_a != cmp_b);
	wire cmp_lt  = (cmp_a < cmp_b);
	wire [7:0] dec_val = opnd - 8'h01;
	wire dec_nz  = (dec_val != 8'h00);
	wire cond_taken = (is_cj & cmp_ne) | (is_dj & dec_nz);
	wire [2:0] total_now = base_cyc + {2'h0, cond_taken};

	// Relative offset sits in the last byte of the instruction.
	wire [7:0]  rel      = (ins_len == 2'h2) ? byte1 : byte2;
	wire [15:0] next_pc  = pc_reg + {14'h0, ins_len};
	wire [15:0] rel_tgt  = next_pc + {{8{rel[7]}}, rel};
	wire [15:0] page_tgt = {next_pc[15:11], op_byte[7:5], byte1};
	wire [15:0] long_tgt = {byte1, byte2};
	wire [15:0] target   = ((cls == cbd_pkg::CL_SHORT) | cond_taken) ? rel_tgt
		: is_page ? page_tgt : is_long ? long_tgt : next_pc;

	// Writes of the decremented value back to its operand.
	wire dj_ram   = eval & ((cls == cbd_pkg::CL_DJ_REG) | ((cls == cbd_pkg::CL_DJ_DIR) & ~dir_sfr));
	wire dj_sfr   = eval & (cls == cbd_pkg::CL_DJ_DIR) & dir_sfr;
	wire dj_psw   = dj_sfr & (byte1 == cbd_pkg::SFR_PSW);
	wire dj_acc   = dj_sfr & (byte1 == cbd_pkg::SFR_ACC);
	wire ram_we   = dj_ram | wr_data;
	wire [7:0] ram_waddr = dj_ram ? first_addr : dbg_addr_reg;
	wire [7:0] ram_wdata = dj_ram ? dec_val : w_data_reg[7:0];

	// Status word: software and decrement write bits 7..1, parity tracks A.
	wire [7:0] acc_next = wr_acc ? w_data_reg[7:0] : dj_acc ? dec_val : acc_reg;
	wire [6:0] psw_hi_wr = wr_psw ? w_data_reg[7:1] : dj_psw ? dec_val[7:1] : psw_reg[7:1];
	wire       carry_nx  = (eval & is_cj) ? cmp_lt : psw_hi_wr[6];
	wire [7:0] psw_next  = {carry_nx, psw_hi_wr[5:0], ^acc_next};

	// ------------------------------------------------------------------
	// Execution sequencer.
	// ------------------------------------------------------------------
	// Busy lasts exactly the documented cycle count; early results wait in pad.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			cbd_pkg::ST_IDLE: begin
				if (start_now) state_next = cbd_pkg::ST_OPND;
			end
			cbd_pkg::ST_OPND: begin
				if (cls == cbd_pkg::CL_CJ_IND) begin
					state_next = cbd_pkg::ST_INDIR;
				end else if (cyc_reg + 3'h1 == total_now) begin
					state_next = cbd_pkg::ST_IDLE;
				end else begin
					state_next = cbd_pkg::ST_PAD;
				end
			end
			cbd_pkg::ST_INDIR: begin
				state_next = (cyc_reg + 3'h1 == total_now) ? cbd_pkg::ST_IDLE : cbd_pkg::ST_PAD;
			end
			cbd_pkg::ST_PAD: begin
				if (cyc_reg + 3'h1 == last_cyc_reg) state_next = cbd_pkg::ST_IDLE;
			end
			default: state_next = cbd_pkg::ST_IDLE;
		endcase
	end

	// Sequencer state and cycle counter.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= cbd_pkg::ST_IDLE;
			cyc_reg   <= 3'h0;
			exec_busy <= 1'b0;
		end else begin
			state_reg <= state_next;
			cyc_reg   <= idle ? 3'h0 : cyc_reg + 3'h1;
			exec_busy <= (state_next != cbd_pkg::ST_IDLE);
		end
	end

	// Architectural state; reserved bits of own registers reset to zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_reg    <= cbd_pkg::INSTR_RST;
			pc_reg       <= cbd_pkg::PC_RST;
			acc_reg      <= cbd_pkg::ACC_RST;
			psw_reg      <= cbd_pkg::PSW_RST;
			dbg_addr_reg <= 8'h00;
			last_cyc_reg <= 3'h0;
			taken_reg    <= 1'b0;
			call_reg     <= 1'b0;
			unsup_reg    <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			psw_reg <= psw_next;
			if (wr_instr & w_strb_reg[0]) instr_reg[7:0]   <= w_data_reg[7:0];
			if (wr_instr & w_strb_reg[1]) instr_reg[15:8]  <= w_data_reg[15:8];
			if (wr_instr & w_strb_reg[2]) instr_reg[23:16] <= w_data_reg[23:16];
			if (wr_pc & w_strb_reg[0]) pc_reg[7:0]  <= w_data_reg[7:0];
			if (wr_pc & w_strb_reg[1]) pc_reg[15:8] <= w_data_reg[15:8];
			if (wr_daddr) dbg_addr_reg <= w_data_reg[7:0];
			if (eval) begin
				pc_reg       <= target;
				last_cyc_reg <= total_now;
				taken_reg    <= cond_taken;
				call_reg     <= (cls == cbd_pkg::CL_PG_CALL) | (cls == cbd_pkg::CL_LG_CALL);
				unsup_reg    <= (cls == cbd_pkg::CL_UNSUP);
			end
		end
	end

	// ------------------------------------------------------------------
	// Internal data memory.
	// ------------------------------------------------------------------
	cbd_ram #(
		.AW (RAM_AW),
		.DW (8)
	) u_ram (
		.aclk      (aclk),
		.we        (ram_we),
		.waddr     (ram_waddr[RAM_AW-1:0]),
		.wdata     (ram_wdata),
		.raddr     (ram_raddr[RAM_AW-1:0]),
		.rdata_reg (ram_rdata)
	);

	// ------------------------------------------------------------------
	// Register bus read channel.
	// ------------------------------------------------------------------
	wire [31:0] status_word = {21'h0, last_cyc_reg, 4'h0, unsup_reg, call_reg,
		taken_reg, ~idle};
	wire [7:0]  ra = s_axi_araddr;
	wire        rd_hit = (ra == cbd_pkg::OFF_CTRL) | (ra == cbd_pkg::OFF_INSTR)
		| (ra == cbd_pkg::OFF_PC) | (ra == cbd_pkg::OFF_ACC) | (ra == cbd_pkg::OFF_STATUS)
		| (ra == cbd_pkg::OFF_DADDR) | (ra == cbd_pkg::OFF_DATA) | (ra == cbd_pkg::OFF_PSW);
	wire [31:0] rd_mux =
		  (ra == cbd_pkg::OFF_INSTR)  ? {8'h00, instr_reg}
		: (ra == cbd_pkg::OFF_PC)     ? {16'h0000, pc_reg}
		: (ra == cbd_pkg::OFF_ACC)    ? {24'h000000, acc_reg}
		: (ra == cbd_pkg::OFF_STATUS) ? status_word
		: (ra == cbd_pkg::OFF_DADDR)  ? {24'h000000, dbg_addr_reg}
		: (ra == cbd_pkg::OFF_DATA)   ? {24'h000000, ram_rdata}
		: (ra == cbd_pkg::OFF_PSW)    ? {24'h000000, psw_reg}
		: 32'h00000000;
	wire ar_take = s_axi_arvalid & s_axi_arready;

	// One read in flight; the answer is registered at the edge that takes the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= cbd_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? cbd_pkg::RESP_OKAY : cbd_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : cbd_branch_decode

`default_nettype wire

//--- logic/cbd_pkg.sv
// Shared constants, types and decode functions of the branch decoder block.
package cbd_pkg;

	// ------------------------------------------------------------------
	// Register map, byte addresses on the 32-bit register bus.
	// ------------------------------------------------------------------
	localparam int          AXI_AW     = 8;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_INSTR  = 8'h04;
	localparam logic [7:0]  OFF_PC     = 8'h08;
	localparam logic [7:0]  OFF_ACC    = 8'h0C;
	localparam logic [7:0]  OFF_STATUS = 8'h10;
	localparam logic [7:0]  OFF_DADDR  = 8'h18;
	localparam logic [7:0]  OFF_DATA   = 8'h1C;
	localparam logic [7:0]  OFF_PSW    = 8'hD0;

	// ------------------------------------------------------------------
	// Field positions and reset values.
	// ------------------------------------------------------------------
	localparam int          CTRL_START   = 0;
	localparam int          STAT_BUSY    = 0;
	localparam int          STAT_TAKEN   = 1;
	localparam int          STAT_CALL    = 2;
	localparam int          STAT_UNSUP   = 3;
	localparam int          STAT_CYC_LSB = 8;
	localparam int          PSW_CARRY    = 7;
	localparam int          PSW_BANK_LSB = 3;
	localparam logic [7:0]  PSW_RST      = 8'h00;
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic [15:0] PC_RST       = 16'h0000;
	localparam logic [23:0] INSTR_RST    = 24'h000000;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------------
	// Special function register addresses in the upper direct half.
	// ------------------------------------------------------------------
	localparam logic [7:0]  SFR_PSW      = 8'hD0;
	localparam logic [7:0]  SFR_ACC      = 8'hE0;
	localparam int          SFR_SEL_BIT  = 7;

	// ------------------------------------------------------------------
	// Opcodes and opcode patterns.
	// ------------------------------------------------------------------
	localparam logic [7:0]  OP_NOP       = 8'h00;
	localparam logic [7:0]  OP_SPARE     = 8'hA5;
	localparam logic [7:0]  OP_CJ_IMM    = 8'hB4;
	localparam logic [7:0]  OP_CJ_DIR    = 8'hB5;
	localparam logic [7:0]  OP_DJ_DIR    = 8'hD5;
	localparam logic [7:0]  OP_SHORT     = 8'h80;
	localparam logic [7:0]  OP_LG_JUMP   = 8'h02;
	localparam logic [7:0]  OP_LG_CALL   = 8'h12;
	localparam logic [6:0]  PFX_CJ_IND   = 7'h5B;
	localparam logic [4:0]  PFX_CJ_REG   = 5'h17;
	localparam logic [4:0]  PFX_DJ_REG   = 5'h1B;
	localparam logic [4:0]  LOW_PG_JUMP  = 5'h01;
	localparam logic [4:0]  LOW_PG_CALL  = 5'h11;

	// ------------------------------------------------------------------
	// Base cycle counts of each instruction without a taken branch.
	// ------------------------------------------------------------------
	localparam logic [2:0]  CYC_NOP      = 3'h1;
	localparam logic [2:0]  CYC_CJ       = 3'h3;
	localparam logic [2:0]  CYC_CJ_IND   = 3'h4;
	localparam logic [2:0]  CYC_DJ_REG   = 3'h2;
	localparam logic [2:0]  CYC_DJ_DIR   = 3'h3;
	localparam logic [2:0]  CYC_PAGE     = 3'h3;
	localparam logic [2:0]  CYC_SHORT    = 3'h3;
	localparam logic [2:0]  CYC_LONG     = 3'h4;

	typedef enum logic [3:0] {
		CL_NOP, CL_CJ_DIR, CL_CJ_IMM, CL_CJ_REG, CL_CJ_IND, CL_DJ_REG, CL_DJ_DIR,
		CL_SHORT, CL_PG_JUMP, CL_PG_CALL, CL_LG_JUMP, CL_LG_CALL, CL_UNSUP
	} cbd_class_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_OPND, ST_INDIR, ST_PAD
	} cbd_state_t;

	// Sorts an opcode into its instruction class.
	function automatic cbd_class_t cbd_classify(input logic [7:0] op);
		cbd_class_t c;
		c = CL_UNSUP;
		case (op)
			OP_NOP, OP_SPARE: c = CL_NOP;
			OP_CJ_DIR:        c = CL_CJ_DIR;
			OP_CJ_IMM:        c = CL_CJ_IMM;
			OP_DJ_DIR:        c = CL_DJ_DIR;
			OP_SHORT:         c = CL_SHORT;
			OP_LG_JUMP:       c = CL_LG_JUMP;
			OP_LG_CALL:       c = CL_LG_CALL;
			default: begin
				// Opcode families are matched on their fixed fields only.
				if (op[7:1] == PFX_CJ_IND)      c = CL_CJ_IND;
				else if (op[7:3] == PFX_CJ_REG) c = CL_CJ_REG;
				else if (op[7:3] == PFX_DJ_REG) c = CL_DJ_REG;
				else if (op[4:0] == LOW_PG_JUMP) c = CL_PG_JUMP;
				else if (op[4:0] == LOW_PG_CALL) c = CL_PG_CALL;
				else                            c = CL_UNSUP;
			end
		endcase
		return c;
	endfunction : cbd_classify

	// Instruction length in bytes.
	function automatic logic [1:0] cbd_length(input cbd_class_t c);
		case (c)
			CL_CJ_DIR, CL_CJ_IMM, CL_CJ_REG, CL_CJ_IND, CL_DJ_DIR,
			CL_LG_JUMP, CL_LG_CALL:           return 2'h3;
			CL_DJ_REG, CL_SHORT, CL_PG_JUMP, CL_PG_CALL: return 2'h2;
			default:                          return 2'h1;
		endcase
	endfunction : cbd_length

	// Cycle count when no conditional branch is taken.
	function automatic logic [2:0] cbd_base_cycles(input cbd_class_t c);
		case (c)
			CL_CJ_DIR, CL_CJ_IMM, CL_CJ_REG: return CYC_CJ;
			CL_CJ_IND:                       return CYC_CJ_IND;
			CL_DJ_REG:                       return CYC_DJ_REG;
			CL_DJ_DIR:                       return CYC_DJ_DIR;
			CL_SHORT:                        return CYC_SHORT;
			CL_PG_JUMP, CL_PG_CALL:          return CYC_PAGE;
			CL_LG_JUMP, CL_LG_CALL:          return CYC_LONG;
			default:                         return CYC_NOP;
		endcase
	endfunction : cbd_base_cycles

	// Data memory address of register idx in the given bank.
	function automatic logic [7:0] cbd_bank_addr(input logic [1:0] bank, input logic [2:0] idx);
		return {3'h0, bank, idx};
	endfunction : cbd_bank_addr

endpackage : cbd_pkg

//--- logic/cbd_ram.sv
// Internal data memory with one write port and a registered read port.
`timescale 1ns/1ns
`default_nettype none

module cbd_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          aclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata_reg
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// A read of the address being written returns the old contents.
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_reg <= mem[raddr];
	end

endmodule : cbd_ram

`default_nettype wire

//--- testbench/cbd_host_model.sv
// Register bus host that drives the block's AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module cbd_host_model (
	input  wire logic        aclk,
	output logic      [7:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [7:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	logic [1:0] bresp_seen;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// Each channel drops only at the edge that takes it; no answer latency is assumed.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		bresp_seen = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : cbd_host_model
`default_nettype wire

//--- testbench/cbd_branch_decode_monitor.sv
// Bus handshake and execution timing checks of the branch decoder.
`timescale 1ns/1ns
`default_nettype none
module cbd_branch_decode_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        exec_busy
);
	logic [3:0] busy_len_reg;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Busy run length; the longest form lasts five cycles.
	always_ff @(posedge aclk)
		busy_len_reg <= (aresetn && exec_busy) ? busy_len_reg + 4'h1 : 4'h0;
	sequence wr_both_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	sequence resp_s;
		##2 s_axi_bvalid;
	endsequence
	wr_resp_time_a: assert property (wr_both_s |-> resp_s) else $error("late write response");
	aw_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address ready not lowered");
	rd_resp_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("late read data");
	rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not released");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address open early");
	busy_bound_a: assert property (busy_len_reg <= 4'h5) else $error("busy too long");
	busy_start_a: assert property ($rose(exec_busy) |-> $rose(s_axi_bvalid))
		else $error("busy without a write");
	reset_idle_a: assert property ($rose(aresetn) |-> !exec_busy && !s_axi_bvalid)
		else $error("not idle after reset");
endmodule : cbd_branch_decode_monitor
bind cbd_branch_decode cbd_branch_decode_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .exec_busy);
`default_nettype wire

//--- testbench/cbd_branch_decode_test.sv
// Self-checking testbench of the branch decoder.
`timescale 1ns/1ns
`default_nettype none
module cbd_branch_decode_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_busy;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	always #4 aclk = ~aclk;
	cbd_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	cbd_branch_decode DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .exec_busy);
	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic poke(input logic [7:0] a, input logic [7:0] v);
		host.wr(cbd_pkg::OFF_DADDR, {24'h0, a});
		host.wr(cbd_pkg::OFF_DATA, {24'h0, v});
	endtask : poke
	// Runs one instruction; start bit alone set, reserved bits left at zero.
	task automatic ex(input logic [23:0] ins, input logic [15:0] pc, npc, input logic [2:0] n);
		int k;
		k = 0;
		host.wr(cbd_pkg::OFF_PC, {16'h0, pc});
		host.wr(cbd_pkg::OFF_INSTR, {8'h0, ins});
		host.wr(cbd_pkg::OFF_CTRL, 32'h1);
		// Busy rises with the response, so every busy cycle is counted here.
		while (exec_busy) begin
			@(posedge aclk);
			k++;
		end
		chk(k, {29'h0, n});
		host.rd(cbd_pkg::OFF_PC, d, r);
		chk(d, {16'h0, npc});
		host.rd(cbd_pkg::OFF_STATUS, d, r);
		chk({29'h0, d[10:8]}, {29'h0, n});
	endtask : ex
	task automatic t_reset();
		host.rd(cbd_pkg::OFF_PSW, d, r);
		chk(d, 32'h0);
		host.rd(8'h40, d, r);
		chk({30'h0, r}, {30'h0, cbd_pkg::RESP_SLVERR});
		host.wr(8'h44, 32'h0);
		chk({30'h0, host.bresp_seen}, {30'h0, cbd_pkg::RESP_SLVERR});
		host.wr(cbd_pkg::OFF_PSW, 32'hFF);
		chk({30'h0, host.bresp_seen}, {30'h0, cbd_pkg::RESP_OKAY});
		host.rd(cbd_pkg::OFF_PSW, d, r);
		chk(d, 32'hFE);
	endtask : t_reset
	task automatic t_cmp();
		host.wr(cbd_pkg::OFF_PSW, 32'h0);
		host.wr(cbd_pkg::OFF_ACC, 32'h5);
		poke(8'h30, 8'h05);
		ex(24'h1030B5, 16'h0100, 16'h0103, 3'h3);
		ex(24'h1007B4, 16'h0100, 16'h0113, 3'h4);
		host.rd(cbd_pkg::OFF_PSW, d, r);
		chk(d, 32'h80);
		host.wr(cbd_pkg::OFF_PSW, 32'h10);
		poke(8'h13, 8'h09);
		ex(24'hFE09BB, 16'h0200, 16'h0203, 3'h3);
		ex(24'hFE08BB, 16'h0200, 16'h0201, 3'h4);
	endtask : t_cmp
	task automatic t_ind();
		host.wr(cbd_pkg::OFF_PSW, 32'h0);
		poke(8'h01, 8'h40);
		poke(8'h40, 8'h22);
		poke(8'h00, 8'h41);
		poke(8'h41, 8'h00);
		ex(24'h0522B7, 16'h0300, 16'h0303, 3'h4);
		ex(24'h0522B6, 16'h0300, 16'h0308, 3'h5);
	endtask : t_ind
	task automatic t_dec();
		host.wr(cbd_pkg::OFF_PSW, 32'h08);
		poke(8'h08, 8'h02);
		ex(24'h0005D8, 16'h0400, 16'h0407, 3'h3);
		chk({28'h0, d[3:0]}, 32'h2);
		ex(24'h0005D8, 16'h0400, 16'h0402, 3'h2);
		ex(24'h0530D5, 16'h0500, 16'h0508, 3'h4);
		host.wr(cbd_pkg::OFF_DADDR, 32'h30);
		host.rd(cbd_pkg::OFF_DATA, d, r);
		chk(d, 32'h4);
		ex(24'h05E0D5, 16'h0500, 16'h0508, 3'h4);
		host.rd(cbd_pkg::OFF_ACC, d, r);
		chk(d, 32'h4);
	endtask : t_dec
	task automatic t_misc();
		ex(24'hFFFFA5, 16'h0600, 16'h0601, 3'h1);
		host.rd(cbd_pkg::OFF_ACC, d, r);
		chk(d, 32'h4);
		ex(24'h003421, 16'h1FFE, 16'h2134, 3'h3);
		ex(24'h003431, 16'h1FFE, 16'h2134, 3'h3);
		chk({28'h0, d[3:0]}, 32'h4);
		ex(24'h341202, 16'h0700, 16'h1234, 3'h4);
		ex(24'h341212, 16'h0700, 16'h1234, 3'h4);
		chk({28'h0, d[3:0]}, 32'h4);
		// An opcode outside the decoded groups runs one cycle and is flagged.
		ex(24'h000004, 16'h0800, 16'h0801, 3'h1);
		chk({28'h0, d[3:0]}, 32'h8);
		ex(24'h008080, 16'h0100, 16'h0082, 3'h3);
	endtask : t_misc
	// A hang ends in the closing report as a mismatch.
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_cmp();
		t_ind();
		t_dec();
		t_misc();
		give_verdict();
	end
endmodule : cbd_branch_decode_test
`default_nettype wire
